// ### hw/ivts_defs.svh
// Purpose: Named constants for the interrupt vector table select block.
// Assumes: Program memory addresses are 24 bits wide, in address units.
// Notes: Included by bare name; definitions only.
`ifndef IVTS_DEFS_SVH
`define IVTS_DEFS_SVH

`define IVTS_ADDR_W 24
`define IVTS_VEC_W 7
`define IVTS_NUM_TRAPS 8
`define IVTS_NUM_IRQS 118
`define IVTS_RESET_ADDR 24'h000000
`define IVTS_RESET_TARGET_ADDR 24'h000002
`define IVTS_TABLE_BASE 24'h000004
`define IVTS_IRQ0_ENTRY 24'h000014
`define IVTS_ALT_IRQ0_ENTRY 24'h000114
`define IVTS_ALT_OFFSET 24'h000100
`define IVTS_LAST_ENTRY 24'h0000fe
`define IVTS_ALT_LAST_ENTRY 24'h0001fe
`define IVTS_CODE_START 24'h000200
`define IVTS_ALT_SEL_BIT 15
`define IVTS_CTRL_W 16

// Trap slots, in natural order.
`define IVTS_TRAP_OSC_FAIL 1
`define IVTS_TRAP_ADDR_ERR 2
`define IVTS_TRAP_STACK_ERR 3
`define IVTS_TRAP_MATH_ERR 4

// Request numbers of implemented sources.
`define IVTS_IRQ_EXT_ZERO 0
`define IVTS_IRQ_CAPTURE_ONE 1
`define IVTS_IRQ_COMPARE_ONE 2
`define IVTS_IRQ_TIMER_ONE 3
`define IVTS_IRQ_CAPTURE_TWO 5
`define IVTS_IRQ_COMPARE_TWO 6
`define IVTS_IRQ_TIMER_TWO 7
`define IVTS_IRQ_TIMER_THREE 8
`define IVTS_IRQ_SPI_ERROR 9
`define IVTS_IRQ_SPI_DONE 10
`define IVTS_IRQ_UART_RX 11
`define IVTS_IRQ_UART_TX 12
`define IVTS_IRQ_CONVERTER 13
`define IVTS_IRQ_I2C_SLAVE 16
`define IVTS_IRQ_I2C_MASTER 17
`define IVTS_IRQ_CHANGE_NOTIFY 19
`define IVTS_IRQ_EXT_ONE 20
`define IVTS_IRQ_CAPTURE_SEVEN 22
`define IVTS_IRQ_CAPTURE_EIGHT 23
`define IVTS_IRQ_EXT_TWO 29

`endif

// ### hw/ivts_pkg.sv
// Purpose: Types shared by the vector table select block.
// Assumes: Nothing beyond the constants header.
// Notes: States use Gray codes along boot, idle, fetch, load.
package ivts_pkg;

  typedef enum logic [1:0]
  {
    IVTS_ST_BOOT = 2'h0,
    IVTS_ST_IDLE = 2'h1,
    IVTS_ST_FETCH = 2'h3,
    IVTS_ST_LOAD = 2'h2
  } ivts_state_e;

endpackage

// ### hw/ivts_prio_enc.sv
// Purpose: Finds the lowest-numbered asserted request line.
// Assumes: Requests are already qualified by enable and user priority.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ns
`default_nettype none

module ivts_prio_enc
#(
  parameter int WIDTH = 126,
  parameter int IDX_W = 7
)
(
  // Request lines.
  input wire logic [WIDTH-1:0] req,
  // Result.
  output logic found,
  output logic [IDX_W-1:0] index
);

  generate
    if (WIDTH > (1 << IDX_W))
    begin : g_bad_width
      $error("ivts_prio_enc: index too narrow for request width");
    end
  endgenerate

  // Scanning downward lets the lowest index be the last to overwrite.
  always_comb
  begin
    found = 1'b0;
    index = '0;
    for (int i = WIDTH - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        found = 1'b1;
        index = IDX_W'(i);
      end
    end
  end

endmodule

`default_nettype wire

// ### hw/ivts_top.sv
// Purpose: Vector table select and vector fetch sequencer.
// Assumes: Requests arrive already qualified; the core answers fetches.
// Notes: Reset restarts the core at the reset address, not through a vector.
`timescale 1ns/1ns
`default_nettype none

`include "ivts_defs.svh"

module ivts_top
#(
  parameter int NUM_IRQS = `IVTS_NUM_IRQS
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Second interrupt control register contents.
  input wire logic [`IVTS_CTRL_W-1:0] interrupt_control_two,
  // Trap sources.
  input wire logic osc_fail_trap,
  input wire logic addr_error_trap,
  input wire logic stack_error_trap,
  input wire logic math_error_trap,
  // Peripheral requests, already qualified.
  input wire logic ext_irq_zero,
  input wire logic capture_one_irq,
  input wire logic compare_one_irq,
  input wire logic timer_one_irq,
  input wire logic capture_two_irq,
  input wire logic compare_two_irq,
  input wire logic timer_two_irq,
  input wire logic timer_three_irq,
  input wire logic spi_error_irq,
  input wire logic spi_done_irq,
  input wire logic uart_receive_irq,
  input wire logic uart_transmit_irq,
  input wire logic converter_done_irq,
  input wire logic i2c_slave_irq,
  input wire logic i2c_master_irq,
  input wire logic change_notify_irq,
  input wire logic ext_irq_one,
  input wire logic capture_seven_irq,
  input wire logic capture_eight_irq,
  input wire logic ext_irq_two,
  input wire logic [NUM_IRQS-1:0] sw_force_irq,
  // Program memory read of a table entry.
  output logic fetch_req,
  output logic [`IVTS_ADDR_W-1:0] fetch_addr,
  input wire logic fetch_valid,
  input wire logic [`IVTS_ADDR_W-1:0] fetch_data,
  // Program counter load toward the core.
  output logic pc_load,
  output logic [`IVTS_ADDR_W-1:0] pc_value,
  // Acknowledge of the taken vector.
  output logic vec_ack,
  output logic [`IVTS_VEC_W-1:0] vec_num,
  output logic alt_table_active
);

  localparam int NUM_VECS = `IVTS_NUM_TRAPS + NUM_IRQS;

  generate
    if (NUM_IRQS < 1 || NUM_IRQS > `IVTS_NUM_IRQS)
    begin : g_bad_irqs
      $error("ivts_top: NUM_IRQS outside the table size");
    end
  endgenerate

  // Entry address of a vector; the alternate table is the same layout
  // shifted up by one fixed offset, so one formula serves both.
  function automatic logic [`IVTS_ADDR_W-1:0] vec_entry_addr
  (
    input logic [`IVTS_VEC_W-1:0] idx,
    input logic alt
  );
    logic [`IVTS_ADDR_W-1:0] base;
    base = alt ? (`IVTS_TABLE_BASE + `IVTS_ALT_OFFSET) : `IVTS_TABLE_BASE;
    vec_entry_addr = base + {16'h0000, idx, 1'b0};
  endfunction

  // The last alternate entry must end below the start of code.
  generate
    if (vec_entry_addr(7'(NUM_VECS - 1), 1'b1) >= `IVTS_CODE_START)
    begin : g_overlap
      $error("ivts_top: vector table overlaps application code");
    end
    if (vec_entry_addr(7'(`IVTS_NUM_TRAPS), 1'b1) != `IVTS_ALT_IRQ0_ENTRY
        || vec_entry_addr(7'(`IVTS_NUM_TRAPS), 1'b0) != `IVTS_IRQ0_ENTRY)
    begin : g_bad_irq0
      $error("ivts_top: request zero entry misplaced");
    end
    if (NUM_IRQS == `IVTS_NUM_IRQS &&
        vec_entry_addr(7'(NUM_VECS - 1), 1'b0) != `IVTS_LAST_ENTRY)
    begin : g_bad_last
      $error("ivts_top: last entry misplaced");
    end
  endgenerate

  logic [NUM_IRQS-1:0] hw_irq;
  logic [`IVTS_NUM_TRAPS-1:0] trap_vec;
  logic [NUM_VECS-1:0] pend_vec;
  logic pend_found;
  logic [`IVTS_VEC_W-1:0] pend_idx;
  ivts_pkg::ivts_state_e state_reg;
  logic alt_sel;

  assign alt_sel = interrupt_control_two[`IVTS_ALT_SEL_BIT];

  // Reserved request slots have no hardware source; only a software force reaches
  // them, so their entries are fetched only on purpose.
  always_comb
  begin
    hw_irq = '0;
    hw_irq[`IVTS_IRQ_EXT_ZERO] = ext_irq_zero;
    hw_irq[`IVTS_IRQ_CAPTURE_ONE] = capture_one_irq;
    hw_irq[`IVTS_IRQ_COMPARE_ONE] = compare_one_irq;
    hw_irq[`IVTS_IRQ_TIMER_ONE] = timer_one_irq;
    hw_irq[`IVTS_IRQ_CAPTURE_TWO] = capture_two_irq;
    hw_irq[`IVTS_IRQ_COMPARE_TWO] = compare_two_irq;
    hw_irq[`IVTS_IRQ_TIMER_TWO] = timer_two_irq;
    hw_irq[`IVTS_IRQ_TIMER_THREE] = timer_three_irq;
    hw_irq[`IVTS_IRQ_SPI_ERROR] = spi_error_irq;
    hw_irq[`IVTS_IRQ_SPI_DONE] = spi_done_irq;
    hw_irq[`IVTS_IRQ_UART_RX] = uart_receive_irq;
    hw_irq[`IVTS_IRQ_UART_TX] = uart_transmit_irq;
    hw_irq[`IVTS_IRQ_CONVERTER] = converter_done_irq;
    hw_irq[`IVTS_IRQ_I2C_SLAVE] = i2c_slave_irq;
    hw_irq[`IVTS_IRQ_I2C_MASTER] = i2c_master_irq;
    hw_irq[`IVTS_IRQ_CHANGE_NOTIFY] = change_notify_irq;
    hw_irq[`IVTS_IRQ_EXT_ONE] = ext_irq_one;
    hw_irq[`IVTS_IRQ_CAPTURE_SEVEN] = capture_seven_irq;
    hw_irq[`IVTS_IRQ_CAPTURE_EIGHT] = capture_eight_irq;
    hw_irq[`IVTS_IRQ_EXT_TWO] = ext_irq_two;
  end

  always_comb
  begin
    trap_vec = '0;
    trap_vec[`IVTS_TRAP_OSC_FAIL] = osc_fail_trap;
    trap_vec[`IVTS_TRAP_ADDR_ERR] = addr_error_trap;
    trap_vec[`IVTS_TRAP_STACK_ERR] = stack_error_trap;
    trap_vec[`IVTS_TRAP_MATH_ERR] = math_error_trap;
  end

  assign pend_vec = {hw_irq | sw_force_irq, trap_vec};

  // Lowest index wins, so traps beat interrupts and low numbers beat high.
  ivts_prio_enc
  #(
    .WIDTH(NUM_VECS),
    .IDX_W(`IVTS_VEC_W)
  )
  u_prio
  (
    .req(pend_vec),
    .found(pend_found),
    .index(pend_idx)
  );

  // Sequencer. Reset lands in the boot state, which loads the counter with
  // the reset address directly instead of fetching any table entry.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= ivts_pkg::IVTS_ST_BOOT;
    end
    else
    begin
      case (state_reg)
        ivts_pkg::IVTS_ST_BOOT:
          state_reg <= ivts_pkg::IVTS_ST_IDLE;
        ivts_pkg::IVTS_ST_IDLE:
          if (pend_found)
          begin
            state_reg <= ivts_pkg::IVTS_ST_FETCH;
          end
        ivts_pkg::IVTS_ST_FETCH:
          if (fetch_valid)
          begin
            state_reg <= ivts_pkg::IVTS_ST_LOAD;
          end
        ivts_pkg::IVTS_ST_LOAD:
          state_reg <= ivts_pkg::IVTS_ST_IDLE;
        default:
          state_reg <= ivts_pkg::IVTS_ST_IDLE;
      endcase
    end
  end

  // The table choice is frozen when a vector is taken, so a change of the
  // select bit during a fetch cannot split one entry across two tables.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      vec_num <= '0;
      alt_table_active <= 1'b0;
      fetch_req <= 1'b0;
      fetch_addr <= `IVTS_RESET_ADDR;
    end
    else if (state_reg == ivts_pkg::IVTS_ST_IDLE && pend_found)
    begin
      vec_num <= pend_idx;
      alt_table_active <= alt_sel;
      fetch_req <= 1'b1;
      fetch_addr <= vec_entry_addr(pend_idx, alt_sel);
    end
    else if (state_reg == ivts_pkg::IVTS_ST_FETCH && fetch_valid)
    begin
      fetch_req <= 1'b0;
    end
  end

  // Counter load: zero at boot, the fetched handler address otherwise.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pc_load <= 1'b0;
      pc_value <= `IVTS_RESET_ADDR;
      vec_ack <= 1'b0;
    end
    else if (state_reg == ivts_pkg::IVTS_ST_BOOT)
    begin
      pc_load <= 1'b1;
      pc_value <= `IVTS_RESET_ADDR;
      vec_ack <= 1'b0;
    end
    else if (state_reg == ivts_pkg::IVTS_ST_FETCH && fetch_valid)
    begin
      pc_load <= 1'b1;
      pc_value <= fetch_data;
      vec_ack <= 1'b1;
    end
    else
    begin
      pc_load <= 1'b0;
      vec_ack <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ### tb/interrupt_vector_table_select_tb_top.sv
// Purpose: Self-checking bench for the vector table select block.
// Assumes: Inputs change on the falling edge.
// Notes: Handler of an entry is its address plus 0x1000 while mirror is low.
`timescale 1ns/1ns
`default_nettype none
module interrupt_vector_table_select_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] ctrl = 16'h0000;
  logic [125:0] vreq = '0;
  logic [117:0] swf = '0;
  logic [3:0] dly = 4'h0;
  logic mirror = 1'b0;
  logic fetch_req, fetch_valid, pc_load, vec_ack, alt_table_active;
  logic [23:0] fetch_addr, fetch_data, pc_value;
  logic [6:0] vec_num;
  int bad_count = 0;
  int checks = 0;
  int src[24] = '{1, 2, 3, 4, 8, 9, 10, 11, 13, 14, 15, 16, 17, 18, 19, 20,
    21, 24, 25, 27, 28, 30, 31, 37};
  always #50 clk = ~clk;
  ivts_top u_ivts_top (.clk(clk), .rstn(rstn),
    .interrupt_control_two(ctrl), .osc_fail_trap(vreq[1]),
    .addr_error_trap(vreq[2]), .stack_error_trap(vreq[3]),
    .math_error_trap(vreq[4]), .ext_irq_zero(vreq[8]),
    .capture_one_irq(vreq[9]), .compare_one_irq(vreq[10]),
    .timer_one_irq(vreq[11]), .capture_two_irq(vreq[13]),
    .compare_two_irq(vreq[14]), .timer_two_irq(vreq[15]),
    .timer_three_irq(vreq[16]), .spi_error_irq(vreq[17]),
    .spi_done_irq(vreq[18]), .uart_receive_irq(vreq[19]),
    .uart_transmit_irq(vreq[20]), .converter_done_irq(vreq[21]),
    .i2c_slave_irq(vreq[24]), .i2c_master_irq(vreq[25]),
    .change_notify_irq(vreq[27]), .ext_irq_one(vreq[28]),
    .capture_seven_irq(vreq[30]), .capture_eight_irq(vreq[31]),
    .ext_irq_two(vreq[37]), .sw_force_irq(swf), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
    .fetch_data(fetch_data), .pc_load(pc_load), .pc_value(pc_value),
    .vec_ack(vec_ack), .vec_num(vec_num),
    .alt_table_active(alt_table_active));
  ivts_core_model u_ivts_core_model (.clk(clk), .rstn(rstn), .delay(dly),
    .mirror(mirror),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_valid(fetch_valid), .fetch_data(fetch_data));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [23:0] exp,
    input logic [23:0] got);
    checks++;
    if (exp !== got)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Waits for the lowest pending vector to be fetched and loaded.
  task automatic take();
    int v;
    int n;
    logic [125:0] all;
    logic [23:0] a;
    logic [23:0] h;
    logic used;
    all = vreq | {swf, 8'h00};
    v = 0;
    while (v < 125 && !all[v])
      v++;
    a = (ctrl[15] ? 24'h000104 : 24'h000004) + 24'(2 * v);
    h = a + 24'h001000;
    used = 1'b0;
    foreach (src[k])
      if (src[k] == v)
        used = 1'b1;
    if (mirror)
      h[8] = 1'b0;
    if (mirror && !used)
      h = 24'h000400;
    n = 0;
    while (fetch_req !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    cmp("fetch_req", 24'h1, 24'(fetch_req));
    cmp("fetch_addr", a, fetch_addr);
    cmp("vec_num", 24'(v), 24'(vec_num));
    vreq = '0;
    swf = '0;
    while (pc_load !== 1'b1 && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    cmp("pc_load", 24'h1, 24'(pc_load));
    cmp("pc_value", h, pc_value);
    cmp("vec_ack", 24'h1, {23'h0, vec_ack});
    cmp("alt_flag", {23'h0, ctrl[15]}, {23'h0, alt_table_active});
    @(negedge clk);
  endtask
  task automatic boot();
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    cmp("boot_load", 24'h1, {23'h0, pc_load});
    cmp("boot_pc", 24'h000000, pc_value);
    @(negedge clk);
  endtask
  initial
  begin
    #2000000;
    bad_count++;
    end_of_test();
  end
  initial
  begin
    int i;
    void'($urandom(5));
    boot();
    for (i = 0; i < 48; i++)
    begin
      ctrl = {i[0], 15'($urandom)};
      dly = 4'($urandom_range(3));
      vreq[src[i / 2]] = 1'b1;
      take();
    end
    for (i = 0; i < 40; i++)
    begin
      ctrl = 16'($urandom);
      dly = 4'($urandom_range(3));
      vreq[src[$urandom_range(23)]] = 1'b1;
      vreq[src[$urandom_range(23)]] = 1'b1;
      swf[$urandom_range(117)] = 1'($urandom_range(1));
      take();
    end
    mirror = 1'b1;
    for (i = 0; i < 6; i++)
    begin
      ctrl[15] = i[0];
      if (i < 4)
        swf[i < 2 ? 117 : 4] = 1'b1;
      else
        vreq[11] = 1'b1;
      take();
    end
    dly = 4'h5;
    vreq[11] = 1'b1;
    repeat (3) @(negedge clk);
    rstn = 1'b0;
    vreq = '0;
    boot();
    vreq[1] = 1'b1;
    vreq[8] = 1'b1;
    take();
    end_of_test();
  end
endmodule
bind ivts_top ivts_checker u_ivts_checker (.clk(clk), .rstn(rstn),
  .interrupt_control_two(interrupt_control_two),
  .osc_fail_trap(osc_fail_trap), .fetch_req(fetch_req),
  .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
  .fetch_data(fetch_data), .pc_load(pc_load), .pc_value(pc_value),
  .vec_ack(vec_ack), .vec_num(vec_num),
  .alt_table_active(alt_table_active));
`default_nettype wire

// ### tb/ivts_checker.sv
// Purpose: Port assertions for the vector table select block.
// Assumes: One clock; rstn is active low.
// Notes: Bound to the top module from the bench top file.
`timescale 1ns/1ns
`default_nettype none
module ivts_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Watched ports.
  input wire logic [15:0] interrupt_control_two,
  input wire logic osc_fail_trap,
  input wire logic fetch_req,
  input wire logic [23:0] fetch_addr,
  input wire logic fetch_valid,
  input wire logic [23:0] fetch_data,
  input wire logic pc_load,
  input wire logic [23:0] pc_value,
  input wire logic vec_ack,
  input wire logic [6:0] vec_num,
  input wire logic alt_table_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_boot_load: assert property ($rose(rstn) |=>
    pc_load && !vec_ack && !fetch_req && pc_value == 24'h000000)
    else $error("boot load missing after reset release");
  chk_fetch_range: assert property (fetch_req |->
    fetch_addr[23:9] == 15'h0000 && fetch_addr[7:0] >= 8'h04
    && !fetch_addr[0])
    else $error("fetch address outside the tables");
  chk_table_select: assert property ($rose(fetch_req) |->
    fetch_addr[8] == $past(interrupt_control_two[15]))
    else $error("fetch read the wrong table");
  chk_entry_spacing: assert property (fetch_req |->
    fetch_addr[7:0] == 8'h04 + {vec_num, 1'b0})
    else $error("entry address does not match vector");
  chk_load_handler: assert property (fetch_req && fetch_valid |=>
    pc_load && vec_ack && pc_value == $past(fetch_data))
    else $error("handler address not loaded");
  chk_load_pulse: assert property (pc_load |=> !pc_load)
    else $error("load pulse longer than one cycle");
  chk_fetch_hold: assert property (fetch_req && !fetch_valid |=>
    fetch_req && $stable(fetch_addr))
    else $error("fetch dropped or moved before answer");
  chk_alt_flag: assert property (vec_ack |->
    pc_load && alt_table_active == $past(fetch_addr[8]))
    else $error("table flag differs from fetch");
  chk_trap_first: assert property ($rose(fetch_req) &&
    $past(osc_fail_trap) |-> vec_num == 7'h01)
    else $error("lowest vector did not win");
  cov_boot: cover property ($rose(rstn) ##1 pc_load);
  cov_alt_take: cover property (vec_ack && alt_table_active);
  cov_slow: cover property ((fetch_req && !fetch_valid) [*3] ##1 fetch_valid);
endmodule
`default_nettype wire

// ### tb/ivts_core_model.sv
// Purpose: Core side that answers table entry reads.
// Assumes: One read at a time; delay set by the bench.
// Notes: Read data is inverted once released, so stale data never matches.
`timescale 1ns/1ns
`default_nettype none
module ivts_core_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Answer delay in cycles.
  input wire logic [3:0] delay,
  // Table image: high follows the advice given to software.
  input wire logic mirror,
  // Entry read.
  input wire logic fetch_req,
  input wire logic [23:0] fetch_addr,
  output logic fetch_valid,
  output logic [23:0] fetch_data
);
  // In the advised image both tables hold the same handlers and every
  // reserved entry points at one default handler, so the select bit then
  // changes nothing and stray vectors land in one known place.
  localparam logic [127:0] USED_VECS = 128'h20db3fef1e;
  localparam logic [23:0] DEFAULT_HANDLER = 24'h000400;
  int wait_cnt;
  logic done;
  logic [7:0] slot;
  logic [23:0] entry_data;
  assign slot = (fetch_addr[7:0] - 8'h04) >> 1;
  always_comb
  begin
    if (!mirror)
      entry_data = fetch_addr + 24'h001000;
    else if (USED_VECS[slot[6:0]])
      entry_data = {fetch_addr[23:9], 1'b0, fetch_addr[7:0]} + 24'h001000;
    else
      entry_data = DEFAULT_HANDLER;
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      fetch_valid <= 1'b0;
      fetch_data <= 24'h000000;
      wait_cnt <= 0;
      done <= 1'b0;
    end
    else
    begin
      fetch_valid <= 1'b0;
      if (fetch_valid)
        fetch_data <= ~fetch_data;
      if (!fetch_req)
      begin
        done <= 1'b0;
        wait_cnt <= 0;
      end
      else if (!done && wait_cnt >= int'(delay))
      begin
        fetch_valid <= 1'b1;
        fetch_data <= entry_data;
        done <= 1'b1;
      end
      else if (!done)
        wait_cnt <= wait_cnt + 1;
    end
  end
endmodule
`default_nettype wire
